//--- hdl/scs_pkg.sv
// constants for the span copy byte shifter
package scs_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_CONFIG   = 4'h0;
  localparam logic [3:0] OFS_SHIFT    = 4'h1;
  localparam logic [3:0] OFS_STATUS   = 4'h2;
  // config field positions
  localparam int CFG_DEPTH_LSB  = 0;
  localparam int CFG_ROP_LSB    = 4;
  localparam int CFG_BMASK_LSB  = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0f0c;
  localparam logic [3:0]  SHIFT_RESET = 4'h0;
  // pixel depth codes
  localparam logic [1:0] DEPTH_8  = 2'h0;
  localparam logic [1:0] DEPTH_16 = 2'h1;
  localparam logic [1:0] DEPTH_32 = 2'h2;
  // copy buffer geometry
  localparam int BUF_BYTES   = 64;
  localparam int QW_BYTES    = 8;
  localparam int BUF_ENTRIES = BUF_BYTES / QW_BYTES;
  localparam logic [2:0] LAST_QW_8BPP  = 3'h3;
  localparam logic [2:0] LAST_QW_WIDE  = 3'h7;
  // span limits in pixels, masked / unmasked
  localparam int SPAN_8_MASKED    = 32;
  localparam int SPAN_8_UNMASKED  = 64;
  localparam int SPAN_16          = 32;
  localparam int SPAN_32          = 16;
  typedef enum logic [1:0] {
    SCS_IDLE = 2'b00,
    SCS_SRC  = 2'b01,
    SCS_DRD  = 2'b11,
    SCS_DWR  = 2'b10
  } scs_state_type;
endpackage

//--- hdl/scs_span_copy.sv
// span copy engine: masked source load and destination drain via byte shifter
// How it works
// - span never exceeds 64-byte copy buffer
// - span limits fixed per pixel depth
// - first write loads buffer from entry zero
// - second write drains buffer, destination mask
// - byte mask and raster op on stores
// - up to four quadwords per 32-byte span
// - shift amount is signed four bits
// - hidden 64-bit residue holds previous read
// - join with residue, rotate by shift
// - extract quadword where read data sat
// - residue takes read quadword, then advance
// - negative shift means backward copy
// - backward copy decrements both addresses
// - forward copy increments both addresses
// - source/destination pointer reset by shift write
module scs_span_copy (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // copy-mode frame buffer writes from host
  input  wire logic        fb_wr_i,
  input  wire logic [31:0] fb_addr_i,
  input  wire logic [31:0] fb_data_i,
  output logic             fb_ready_o,
  // frame buffer memory
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [28:0] mem_addr_o,
  output logic      [63:0] mem_wdata_o,
  output logic      [7:0]  mem_be_o,
  input  wire logic        mem_ack_i,
  input  wire logic [63:0] mem_rdata_i
);

  scs_pkg::scs_state_type state;
  logic [31:0] cfg;
  logic [3:0]  shift_amount_register;
  logic        dest_next;
  logic [63:0] residue;
  logic [63:0] cbuf [scs_pkg::BUF_ENTRIES];
  logic [63:0] dst_data;
  logic [31:0] span_mask;
  logic [2:0]  step;
  logic        backward;

  logic [1:0]  depth;
  logic [3:0]  rop;
  logic [3:0]  bmask;
  logic [7:0]  step_be;
  logic [2:0]  last_step;
  logic        step_done;
  logic        fb_take;
  logic [63:0] shifted;

  assign depth = cfg[scs_pkg::CFG_DEPTH_LSB +: 2];
  assign rop   = cfg[scs_pkg::CFG_ROP_LSB +: 4];
  assign bmask = cfg[scs_pkg::CFG_BMASK_LSB +: 4];

  // byte enables of quadword k from the 32-bit pixel mask
  function automatic logic [7:0] qw_enables(input logic [31:0] m, input logic [1:0] d,
                                            input logic [2:0] k);
    logic [7:0] be;
    be = 8'h00;
    for (int i = 0; i < 8; i++) begin
      unique case (d)
        scs_pkg::DEPTH_16: be[i] = m[{k, 2'b00} + 5'(i / 2)];
        scs_pkg::DEPTH_32: be[i] = m[{1'b0, k, 1'b0} + 5'(i / 4)];
        default:           be[i] = m[{k[1:0], 3'b000} + 5'(i)];
      endcase
    end
    return be;
  endfunction

  // byte rotation of the joined residue and fresh read
  function automatic logic [63:0] rotate_pick(input logic [63:0] fresh, input logic [63:0] res,
                                              input logic [3:0] s);
    logic [255:0] dbl;
    logic [127:0] rot;
    logic [7:0]   n;
    dbl = {fresh, res, fresh, res};
    if (s[3]) begin
      n   = 8'({4'h0, (~s + 4'h1)} * 8'h08);
      rot = dbl[255 - n -: 128];
    end else begin
      n   = 8'({4'h0, s} * 8'h08);
      rot = dbl[n +: 128];
    end
    return rot[127:64];
  endfunction

  // per-bit raster op: result bit = rop[{src, dst}]
  function automatic logic [63:0] raster(input logic [63:0] s, input logic [63:0] d,
                                         input logic [3:0] op);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 64; i++) begin
      r[i] = op[{s[i], d[i]}];
    end
    return r;
  endfunction

  // four quadwords at 8 bpp, eight at wider depths
  assign last_step = (depth == scs_pkg::DEPTH_8) ? scs_pkg::LAST_QW_8BPP
                                                 : scs_pkg::LAST_QW_WIDE;
  // 32-bit mask and eight entries keep span within buffer
  assign step_be = qw_enables(span_mask, depth, step) &
                   {bmask, bmask};
  assign step_done = (step == last_step);
  // only accepted while idle and ready
  assign fb_take = fb_wr_i && fb_ready_o;
  // rotate joined value; keep upper quadword
  assign shifted = rotate_pick(mem_rdata_i, residue, shift_amount_register);

  // register writes
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg                   <= scs_pkg::CFG_RESET;
      shift_amount_register <= scs_pkg::SHIFT_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == scs_pkg::OFS_CONFIG) begin
        cfg <= reg_wdata_i;
      end
      if (reg_addr_i == scs_pkg::OFS_SHIFT) begin
        shift_amount_register <= reg_wdata_i[3:0];
      end
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        scs_pkg::OFS_CONFIG: reg_rdata_o <= cfg;
        scs_pkg::OFS_SHIFT:  reg_rdata_o <= {28'h0, shift_amount_register};
        scs_pkg::OFS_STATUS: reg_rdata_o <= {29'h0, backward, dest_next, !fb_ready_o};
        default:             reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dest_next <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == scs_pkg::OFS_SHIFT) begin
      dest_next <= 1'b0;
    end else if (fb_take) begin
      dest_next <= !dest_next;
    end
  end

  // copy sequencer and memory requests
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state       <= scs_pkg::SCS_IDLE;
      fb_ready_o  <= 1'b1;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= 29'h0;
      mem_wdata_o <= 64'h0;
      mem_be_o    <= 8'h00;
      span_mask   <= 32'h0;
      step        <= 3'h0;
      backward    <= 1'b0;
      residue     <= 64'h0;
      dst_data    <= 64'h0;
    end else begin
      unique case (state)
        scs_pkg::SCS_IDLE: begin
          if (fb_take) begin
            fb_ready_o <= 1'b0;
            step       <= 3'h0;
            backward   <= shift_amount_register[3];
            mem_addr_o <= fb_addr_i[31:3];
            // 16 mask bits at 32 bpp, 32 otherwise
            span_mask  <= (depth == scs_pkg::DEPTH_32) ? {16'h0, fb_data_i[15:0]} : fb_data_i;
            state      <= dest_next ? scs_pkg::SCS_DRD : scs_pkg::SCS_SRC;
          end
        end
        scs_pkg::SCS_SRC: begin
          if (mem_req_o) begin
            if (mem_ack_i) begin
              mem_req_o <= 1'b0;
              // residue keeps the quadword just read
              residue   <= mem_rdata_i;
              if (step_done) begin
                state      <= scs_pkg::SCS_IDLE;
                fb_ready_o <= 1'b1;
              end else begin
                step <= step + 3'h1;
                // backward steps down; forward steps up
                mem_addr_o <= backward ? mem_addr_o - 29'h1 : mem_addr_o + 29'h1;
              end
            end
          end else if (step_be == 8'h00) begin
            // masked-off quadword: no read, residue cleared
            residue <= 64'h0;
            if (step_done) begin
              state      <= scs_pkg::SCS_IDLE;
              fb_ready_o <= 1'b1;
            end else begin
              step <= step + 3'h1;
              mem_addr_o <= backward ? mem_addr_o - 29'h1 : mem_addr_o + 29'h1;
            end
          end else begin
            mem_req_o <= 1'b1;
            mem_we_o  <= 1'b0;
            mem_be_o  <= step_be;
          end
        end
        scs_pkg::SCS_DRD: begin
          if (mem_req_o) begin
            if (mem_ack_i) begin
              // destination read feeds the raster op
              dst_data    <= mem_rdata_i;
              mem_req_o   <= 1'b0;
              mem_we_o    <= 1'b1;
              state       <= scs_pkg::SCS_DWR;
            end
          end else if (step_be == 8'h00) begin
            if (step_done) begin
              state      <= scs_pkg::SCS_IDLE;
              fb_ready_o <= 1'b1;
            end else begin
              step       <= step + 3'h1;
              mem_addr_o <= backward ? mem_addr_o - 29'h1 : mem_addr_o + 29'h1;
            end
          end else begin
            mem_req_o <= 1'b1;
            mem_we_o  <= 1'b0;
            mem_be_o  <= step_be;
          end
        end
        scs_pkg::SCS_DWR: begin
          if (!mem_req_o && mem_we_o) begin
            // byte mask folded into byte enables
            mem_req_o   <= 1'b1;
            mem_be_o    <= step_be;
            // raster op of entry against stored destination
            mem_wdata_o <= raster(cbuf[step], dst_data, rop);
          end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_we_o  <= 1'b0;
            if (step_done) begin
              state      <= scs_pkg::SCS_IDLE;
              fb_ready_o <= 1'b1;
            end else begin
              step       <= step + 3'h1;
              state      <= scs_pkg::SCS_DRD;
              mem_addr_o <= backward ? mem_addr_o - 29'h1 : mem_addr_o + 29'h1;
            end
          end
        end
      endcase
    end
  end

  // rotated quadword into entry of this step
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < scs_pkg::BUF_ENTRIES; i++) begin
        cbuf[i] <= 64'h0;
      end
    end else if (state == scs_pkg::SCS_SRC && mem_req_o && mem_ack_i) begin
      cbuf[step] <= shifted;
    end
  end

endmodule

//--- sim/scs_fb_mem.sv
// frame buffer memory model, 64 quadwords, fast or slow ack
module scs_fb_mem (
  // clock and mode
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        slow_i,
  // request side
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [28:0] addr_i,
  input  wire logic [63:0] wdata_i,
  input  wire logic [7:0]  be_i,
  output logic             ack_o,
  output logic      [63:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] q [64];
  logic [2:0]  wait_cnt;
  // ack never in the cycle the request rises; data churns outside ack
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o    <= 1'b0;
      wait_cnt <= 3'h0;
      rdata_o  <= 64'h0;
    end else if (ack_o || !req_i || wait_cnt != (slow_i ? 3'h4 : 3'h1)) begin
      ack_o    <= 1'b0;
      wait_cnt <= (ack_o || !req_i) ? 3'h0 : wait_cnt + 3'h1;
      rdata_o  <= ~rdata_o;
    end else begin
      ack_o   <= 1'b1;
      rdata_o <= q[addr_i[5:0]];
      for (int i = 0; i < 8; i++)
        if (we_i && be_i[i]) q[addr_i[5:0]][8*i +: 8] <= wdata_i[8*i +: 8];
    end
  end
endmodule

//--- sim/scs_span_copy_checker.sv
// port assertions for the span copy engine
module scs_span_copy_checker (
  // clock, reset and registers
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // copy port and memory
  input wire logic        fb_wr_i,
  input wire logic        fb_ready_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [28:0] mem_addr_o,
  input wire logic [63:0] mem_wdata_o,
  input wire logic [7:0]  mem_be_o,
  input wire logic        mem_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // acks per operation: a drain reads and writes 8 quadwords at most
  logic [4:0] n_ack;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) n_ack <= 5'h0;
    else if (fb_ready_o) n_ack <= 5'h0;
    else if (mem_req_o && mem_ack_i) n_ack <= n_ack + 5'h1;
  end
  a_take_busy: assert property (
    fb_wr_i && fb_ready_o |=> !fb_ready_o) else $error("ready stayed high after take");
  a_idle_quiet: assert property (
    fb_ready_o |-> !mem_req_o) else $error("memory request while idle");
  a_req_held: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("request changed before ack");
  a_data_held: assert property (
    mem_req_o && !mem_ack_i |=> $stable(mem_wdata_o) && $stable(mem_be_o))
    else $error("write data changed before ack");
  a_masked_only: assert property (
    mem_req_o |-> mem_be_o != 8'h0) else $error("request with no byte enabled");
  a_span_bound: assert property (
    n_ack <= 5'h10) else $error("too many quadwords in one operation");
  a_ack_drop: assert property (
    mem_req_o && mem_ack_i |=> !mem_req_o) else $error("request held after ack");
  a_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 32'h0) else $error("read data without read");
  a_shift_width: assert property (
    reg_rd_i && reg_addr_i == scs_pkg::OFS_SHIFT |=> reg_rdata_o[31:4] == 28'h0)
    else $error("shift amount wider than four bits");
  c_take: cover property (fb_wr_i && fb_ready_o);
  c_store: cover property (mem_req_o && mem_we_o && mem_ack_i);
  c_full: cover property (n_ack == 5'h10);
endmodule

bind scs_span_copy scs_span_copy_checker chk (.mclk_i, .rst_b_i, .reg_addr_i, .reg_rd_i,
  .reg_rdata_o, .fb_wr_i, .fb_ready_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
  .mem_be_o, .mem_ack_i);

//--- sim/scs_span_copy_tb_top.sv
// self-checking bench for the span copy engine
module scs_span_copy_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, rst_b_i, reg_wr_i, reg_rd_i, fb_wr_i, slow;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, fb_addr_i, fb_data_i;
  logic        fb_ready_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [28:0] mem_addr_o;
  logic [63:0] mem_wdata_o, mem_rdata_i, model [64];
  logic [7:0]  mem_be_o;
  int          n_errors, comparisons;
  scs_span_copy uut (.mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .fb_wr_i, .fb_addr_i, .fb_data_i, .fb_ready_o, .mem_req_o, .mem_we_o,
    .mem_addr_o, .mem_wdata_o, .mem_be_o, .mem_ack_i, .mem_rdata_i);
  scs_fb_mem mem (.clk_i(mclk_i), .rst_b_i, .slow_i(slow), .req_i(mem_req_o),
    .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .be_i(mem_be_o),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk(64'(reg_rdata_o), 64'(e));
  endtask
  // host side: quadword-rounded address, mask as data
  task automatic fbw(input logic [5:0] qa, input logic [31:0] m);
    @(posedge mclk_i);
    fb_addr_i <= {23'h0, qa, 3'h0};
    fb_data_i <= m;
    fb_wr_i   <= 1'b1;
    @(posedge mclk_i);
    fb_wr_i <= 1'b0;
    // busy must show after the take edge, so look from the next negedge on
    @(negedge mclk_i);
    chk(64'(fb_ready_o), 64'h0);
    for (int i = 0; i < 400 && fb_ready_o !== 1'b1; i++) @(negedge mclk_i);
    chk(64'(fb_ready_o), 64'h1);
  endtask
  function automatic logic [7:0] bemask(input logic [1:0] d, input logic [31:0] m, input int k);
    logic [7:0] b;
    for (int i = 0; i < 8; i++)
      b[i] = (d == scs_pkg::DEPTH_8) ? m[8*k+i] : (d == scs_pkg::DEPTH_16) ? m[4*k+i/2]
           : (2*k+i/4 < 16) & m[2*k+i/4];
    return b;
  endfunction
  task automatic copy(input logic [1:0] d, input logic [3:0] s, input logic [5:0] sa,
                      input logic [31:0] ms, input logic [5:0] da, input logic [31:0] md);
    logic [63:0]  res, ent [8];
    logic [127:0] x;
    int           st, n;
    res = 64'h0;
    st  = s[3] ? -1 : 1;
    n   = (d == scs_pkg::DEPTH_8) ? 4 : 8;
    // all bytes enabled, raster op 0xc passes the source through
    wr(scs_pkg::OFS_CONFIG, {20'h0, 4'hf, 4'hc, 2'h0, d});
    wr(scs_pkg::OFS_SHIFT, {28'h0, s});
    fbw(sa, ms);
    fbw(da, md);
    for (int k = 0; k < n; k++) begin
      x   = {model[6'(sa + st * k)], res};
      res = (bemask(d, ms, k) != 8'h0) ? x[127:64] : 64'h0;
      x   = s[3] ? (x << (8 * (16 - s))) | (x >> (128 - 8 * (16 - s)))
                 : (x >> (8 * s)) | (x << (128 - 8 * s));
      ent[k] = x[127:64];
    end
    for (int k = 0; k < n; k++)
      for (int i = 0; i < 8; i++)
        if (bemask(d, md, k) & (8'h1 << i)) model[6'(da + st * k)][8*i +: 8] = ent[k][8*i +: 8];
    for (int i = 0; i < 64; i++) chk(mem.q[i], model[i]);
  endtask
  task automatic t_regs;
    rd(scs_pkg::OFS_CONFIG, scs_pkg::CFG_RESET);
    rd(scs_pkg::OFS_SHIFT, 32'h0);
    rd(4'h3, 32'h0);
    wr(scs_pkg::OFS_SHIFT, 32'hffff_fff9);
    rd(scs_pkg::OFS_SHIFT, 32'h9);
    $display("test regs done");
  endtask
  task automatic t_ptr;
    wr(scs_pkg::OFS_STATUS, 32'hffff_ffff);
    wr(scs_pkg::OFS_SHIFT, 32'h0);
    rd(scs_pkg::OFS_STATUS, 32'h0);
    fbw(6'h00, 32'h0);
    rd(scs_pkg::OFS_STATUS, 32'h2);
    wr(scs_pkg::OFS_SHIFT, 32'h0);
    rd(scs_pkg::OFS_STATUS, 32'h0);
    $display("test pointer done");
  endtask
  task automatic t_copies;
    copy(scs_pkg::DEPTH_8, 4'h0, 6'h00, 32'hffff_ffff, 6'h10, 32'hffff_ffff);
    slow = 1'b1;
    copy(scs_pkg::DEPTH_32, 4'h0, 6'h08, 32'hffff_ffff, 6'h28, 32'h0000_ffff);
    slow = 1'b0;
    copy(scs_pkg::DEPTH_16, 4'h2, 6'h18, 32'h0fff_fff0, 6'h1e, 32'h0fff_fff0);
    copy(scs_pkg::DEPTH_8, 4'hf, 6'h3c, 32'hffff_ff00, 6'h34, 32'hffff_ff00);
    $display("test copies done");
  endtask
  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, fb_wr_i, slow} = 5'h0;
    {reg_addr_i, reg_wdata_i, fb_addr_i, fb_data_i} = '0;
    n_errors    = 0;
    comparisons = 0;
    for (int i = 0; i < 64; i++) begin
      model[i] = {8{i[7:0]}} ^ 64'hf0e1_d2c3_b4a5_9687;
      mem.q[i] = model[i];
    end
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_ptr;
    t_copies;
    complete_run;
  end
  // hang guard, well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    complete_run;
  end
endmodule
